// ---- hw/axl_pkg.sv ----
// Shared constants and types for the link procedure engine
// Operation
// - Seize request answered by confirm at opportunity
// - Pending ack seizes; frame chosen at transmit
// - Seize channel before sending, release afterwards
// - Separate busy and quiet channel indications
// - Expedited frames use distinct transmit request
// - Modem signals acquisition and loss of signal
// - Explicit transmitter key on and off signals
// - Destination then source address, source is own
// - Equal C bits mark an older peer
// - Command C bits 1/0, response 0/1
// - Polled SABM or DISC gets final UA/DM
// - Polled I/S when connected gets final RR
// - Polled I/S when disconnected gets final DM
// - Unused poll/final bit sent as zero
// - Send SABM and start T1 together
// - Accepting station sends UA, resets variables
// - UA stops T1 and zeroes state variables
// - T1 expiry resends SABM, gives up after N2
// - Refuse with DM; DM stops T1, no connect
// - Awaiting UA, discard all but SABM/DISC/UA/DM
// - Answering SABM sends only UA or DM
// - Defaults T1 3000 ms and N2 of 10
// - DM unsolicited final 0; SABM/DISC poll 1
package axl_pkg;
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int T1_MS = 3000;
  localparam int T1_CYC = T1_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 25;
  localparam logic [CNT_W-1:0] T1_DEF = CNT_W'(T1_CYC);
  localparam logic [7:0] N2_DEF = 8'h0a;
  localparam int ADDR_W = 8;
  // Command/response C bit encodings
  localparam logic CMD_DEST_C = 1'b1;
  localparam logic CMD_SRC_C = 1'b0;
  localparam logic RSP_DEST_C = 1'b0;
  localparam logic RSP_SRC_C = 1'b1;
  localparam logic [8:0] SEQ_RST = 9'h000;
  localparam logic [7:0] ATT_RST = 8'h00;
  // Frame types
  typedef enum logic [2:0] {
    FT_I = 3'h0, FT_RR = 3'h1, FT_RNR = 3'h2, FT_REJ = 3'h3,
    FT_SABM = 3'h4, FT_DISC = 3'h5, FT_UA = 3'h6, FT_DM = 3'h7
  } axl_ftype_t;
  // Frame descriptor carried across the link
  typedef struct packed {
    axl_ftype_t ftype;
    logic pf;
    logic destC;
    logic srcC;
    logic [ADDR_W-1:0] dest;
    logic [ADDR_W-1:0] src;
  } axl_frame_t;
  // Data-link states
  typedef enum logic [1:0] {
    DL_DISC = 2'h0, DL_AWAIT = 2'h1, DL_CONN = 2'h3
  } axl_dl_t;
  // Transmit sequencer states
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0, TX_WAITQ = 2'h1, TX_KEY = 2'h3, TX_REL = 2'h2
  } axl_tx_t;
endpackage : axl_pkg

// ---- hw/axl_link_if.sv ----
// Link carrier between the station and the distant partner
`timescale 1ns/1ps
interface axl_link_if;
  import axl_pkg::*;
  axl_frame_t devFrame;
  logic devValid;
  logic devTxOn;
  logic devTxOff;
  axl_frame_t ptnFrame;
  logic ptnValid;
  logic ptnAcq;
  logic ptnLoss;
  modport dev (output devFrame, devValid, devTxOn, devTxOff, input ptnFrame, ptnValid, ptnAcq, ptnLoss);
  modport ptn (input devFrame, devValid, devTxOn, devTxOff, output ptnFrame, ptnValid, ptnAcq, ptnLoss);
endinterface : axl_link_if

// ---- hw/axl_timer.sv ----
// One-shot acknowledge timer with start, stop and expiry pulse
`timescale 1ns/1ps
module axl_timer (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic stop,
  input wire logic [axl_pkg::CNT_W-1:0] period,
  output logic expired
);
  import axl_pkg::*;
  logic [CNT_W-1:0] cntQ, cntD;
  logic runQ, runD, expD;

  // Stop wins over start; expiry pulses once
  always_comb begin
    cntD = cntQ;
    runD = runQ;
    expD = 1'b0;
    if (stop) begin
      runD = 1'b0;
    end else if (start) begin
      cntD = period;
      runD = 1'b1;
    end else if (runQ) begin
      if (cntQ <= CNT_W'(1)) begin
        runD = 1'b0;
        expD = 1'b1;
      end else begin
        cntD = cntQ - CNT_W'(1);
      end
    end
  end

  // Registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cntQ <= '0;
      runQ <= 1'b0;
      expired <= 1'b0;
    end else begin
      cntQ <= cntD;
      runQ <= runD;
      expired <= expD;
    end
  end
endmodule : axl_timer

// ---- hw/axl_station.sv ----
// Local station: data-link, link multiplexer and physical sequencing
`timescale 1ns/1ps
module axl_station #(
  parameter logic [axl_pkg::CNT_W-1:0] T1_DEFAULT = axl_pkg::T1_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  axl_link_if.dev lnk,
  input wire logic [axl_pkg::ADDR_W-1:0] myAddr,
  input wire logic [axl_pkg::ADDR_W-1:0] peerAddr,
  input wire logic connReq,
  input wire logic ackReq,
  input wire logic acceptEn,
  input wire logic expValid,
  input wire axl_pkg::axl_frame_t expFrame,
  input wire logic cfgWrite,
  input wire logic [axl_pkg::CNT_W-1:0] t1Cfg,
  input wire logic [7:0] n2Cfg,
  output logic linkUp,
  output logic connFail,
  output logic peerOld,
  output logic expBusy,
  output logic [8:0] seqVars
);
  import axl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  axl_dl_t dlQ, dlD;
  axl_tx_t txQ, txD;
  logic [8:0] seqQ, seqD;
  logic respPendQ, respPendD, respPfQ, respPfD;
  axl_ftype_t respQ, respD;
  logic sabmDueQ, sabmDueD, ackPendQ, ackPendD;
  logic [7:0] attemptQ, attemptD, n2Q, n2D;
  logic [CNT_W-1:0] t1Q, t1D;
  logic peerOldD, connFailD;
  logic t1Start, t1Stop, t1Exp;
  logic chanFreeQ, chanFreeD;
  logic expPendQ, expPendD;
  axl_frame_t expBufQ, expBufD, frameQ, frameD, rx;
  logic validQ, validD, onQ, onD, offQ, offD;
  logic lmSeizeReq, seizeCnf, sendResp, sendSabm, sendAck;
  logic rxOk, rxCmd;

  // Build a frame to the peer from this station
  function automatic axl_frame_t mkFrame(axl_ftype_t ft, logic pf, logic cmd);
    axl_frame_t f;
    f.ftype = ft;
    f.pf = pf;
    f.destC = cmd ? CMD_DEST_C : RSP_DEST_C;
    f.srcC = cmd ? CMD_SRC_C : RSP_SRC_C;
    f.dest = peerAddr;
    f.src = myAddr;
    return f;
  endfunction : mkFrame

  // Received frame qualification
  assign rx = lnk.ptnFrame;
  assign rxOk = lnk.ptnValid && (rx.dest == myAddr) && (rx.src == peerAddr);
  assign rxCmd = rx.destC && !rx.srcC;
  assign lmSeizeReq = respPendQ || sabmDueQ || ackPendQ;

  axl_timer u_t1 (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(t1Start),
    .stop(t1Stop),
    .period(t1Q),
    .expired(t1Exp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Data-link machine next state
  always_comb begin
    dlD = dlQ;
    seqD = seqQ;
    respPendD = respPendQ;
    respD = respQ;
    respPfD = respPfQ;
    sabmDueD = sabmDueQ;
    ackPendD = ackPendQ;
    attemptD = attemptQ;
    t1D = t1Q;
    n2D = n2Q;
    peerOldD = peerOld;
    connFailD = 1'b0;
    t1Start = 1'b0;
    t1Stop = 1'b0;
    if (cfgWrite) begin
      t1D = t1Cfg;
      n2D = n2Cfg;
    end
    // Frames consumed at the seize confirm
    if (sendResp) begin
      respPendD = 1'b0;
    end
    if (sendSabm) begin
      sabmDueD = 1'b0;
      attemptD = attemptQ + 8'h01;
      t1Start = 1'b1;
    end
    if (sendAck) begin
      ackPendD = 1'b0;
    end
    // Connect request and retry
    case (dlQ)
      DL_DISC: begin
        if (connReq) begin
          dlD = DL_AWAIT;
          sabmDueD = 1'b1;
          attemptD = ATT_RST;
        end
      end
      DL_AWAIT: begin
        if (t1Exp) begin
          if (attemptQ >= n2Q) begin
            dlD = DL_DISC;
            connFailD = 1'b1;
          end else begin
            sabmDueD = 1'b1;
          end
        end
      end
      DL_CONN: begin
      end
      default: begin
        dlD = DL_DISC;
      end
    endcase
    // Received frames; a new response overrides the clear above
    if (rxOk) begin
      peerOldD = (rx.destC == rx.srcC);
      case (rx.ftype)
        FT_SABM: begin
          if (rxCmd) begin
            respPendD = 1'b1;
            respPfD = rx.pf;
            sabmDueD = 1'b0;
            t1Stop = 1'b1;
            if (acceptEn) begin
              respD = FT_UA;
              dlD = DL_CONN;
              seqD = SEQ_RST;
            end else begin
              respD = FT_DM;
              dlD = DL_DISC;
            end
          end
        end
        FT_DISC: begin
          if (rxCmd) begin
            respPendD = 1'b1;
            respPfD = rx.pf;
            respD = (dlQ == DL_CONN) ? FT_UA : FT_DM;
            dlD = DL_DISC;
            sabmDueD = 1'b0;
            t1Stop = 1'b1;
          end
        end
        FT_UA: begin
          if (!rxCmd && dlQ == DL_AWAIT) begin
            t1Stop = 1'b1;
            seqD = SEQ_RST;
            dlD = DL_CONN;
            sabmDueD = 1'b0;
          end
        end
        FT_DM: begin
          if (!rxCmd && dlQ != DL_DISC) begin
            t1Stop = 1'b1;
            sabmDueD = 1'b0;
            connFailD = (dlQ == DL_AWAIT);
            dlD = DL_DISC;
          end
        end
        default: begin
          // I and S frames are discarded while awaiting UA
          if (dlQ != DL_AWAIT && rxCmd && rx.pf) begin
            respPendD = 1'b1;
            respPfD = 1'b1;
            respD = (dlQ == DL_CONN) ? FT_RR : FT_DM;
          end
        end
      endcase
    end
    if (ackReq && dlQ == DL_CONN) begin
      ackPendD = 1'b1;
    end
    if (dlD != DL_CONN) begin
      ackPendD = 1'b0;
    end
  end

  // Data-link registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      dlQ <= DL_DISC;
      seqQ <= SEQ_RST;
      respPendQ <= 1'b0;
      respQ <= FT_DM;
      respPfQ <= 1'b0;
      sabmDueQ <= 1'b0;
      ackPendQ <= 1'b0;
      attemptQ <= ATT_RST;
      t1Q <= T1_DEFAULT;
      n2Q <= N2_DEF;
      peerOld <= 1'b0;
      connFail <= 1'b0;
      linkUp <= 1'b0;
    end else begin
      dlQ <= dlD;
      seqQ <= seqD;
      respPendQ <= respPendD;
      respQ <= respD;
      respPfQ <= respPfD;
      sabmDueQ <= sabmDueD;
      ackPendQ <= ackPendD;
      attemptQ <= attemptD;
      t1Q <= t1D;
      n2Q <= n2D;
      peerOld <= peerOldD;
      connFail <= connFailD;
      linkUp <= (dlD == DL_CONN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multiplexer and physical sequencing next state
  always_comb begin
    txD = txQ;
    chanFreeD = chanFreeQ;
    expPendD = expPendQ;
    expBufD = expBufQ;
    frameD = frameQ;
    validD = 1'b0;
    onD = 1'b0;
    offD = 1'b0;
    seizeCnf = 1'b0;
    sendResp = 1'b0;
    sendSabm = 1'b0;
    sendAck = 1'b0;
    if (lnk.ptnAcq) begin
      chanFreeD = 1'b0;
    end else if (lnk.ptnLoss) begin
      chanFreeD = 1'b1;
    end
    case (txQ)
      TX_IDLE: begin
        if (lmSeizeReq || expPendQ) begin
          txD = TX_WAITQ;
        end
      end
      TX_WAITQ: begin
        if (chanFreeQ) begin
          onD = 1'b1;
          txD = TX_KEY;
        end
      end
      TX_KEY: begin
        seizeCnf = 1'b1;
        txD = TX_REL;
        if (expPendQ) begin
          frameD = expBufQ;
          validD = 1'b1;
          expPendD = 1'b0;
        end else if (respPendQ) begin
          frameD = mkFrame(respQ, respPfQ, 1'b0);
          validD = 1'b1;
          sendResp = 1'b1;
        end else if (sabmDueQ && dlQ == DL_AWAIT) begin
          frameD = mkFrame(FT_SABM, 1'b1, 1'b1);
          validD = 1'b1;
          sendSabm = 1'b1;
        end else if (ackPendQ && dlQ == DL_CONN) begin
          frameD = mkFrame(FT_RR, 1'b0, 1'b0);
          validD = 1'b1;
          sendAck = 1'b1;
        end
      end
      TX_REL: begin
        offD = 1'b1;
        txD = TX_IDLE;
      end
      default: begin
        txD = TX_IDLE;
      end
    endcase
    if (expValid && !expPendD) begin
      expPendD = 1'b1;
      expBufD = expFrame;
    end
  end

  // Multiplexer and physical registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      txQ <= TX_IDLE;
      chanFreeQ <= 1'b1;
      expPendQ <= 1'b0;
      expBufQ <= '0;
      frameQ <= '0;
      validQ <= 1'b0;
      onQ <= 1'b0;
      offQ <= 1'b0;
    end else begin
      txQ <= txD;
      chanFreeQ <= chanFreeD;
      expPendQ <= expPendD;
      expBufQ <= expBufD;
      frameQ <= frameD;
      validQ <= validD;
      onQ <= onD;
      offQ <= offD;
    end
  end

  // Outputs
  assign lnk.devFrame = frameQ;
  assign lnk.devValid = validQ;
  assign lnk.devTxOn = onQ;
  assign lnk.devTxOff = offQ;
  assign expBusy = expPendQ;
  assign seqVars = seqQ;
endmodule : axl_station

// ---- hw/axl_partner.sv ----
// Distant station and its modem across the shared channel
`timescale 1ns/1ps
module axl_partner (
  input wire logic ref_clk,
  input wire logic rst_b,
  axl_link_if.ptn lnk,
  input wire logic [axl_pkg::ADDR_W-1:0] ownAddr,
  input wire logic [axl_pkg::ADDR_W-1:0] peerAddr,
  input wire logic acceptEn,
  input wire logic cmdReq,
  input wire axl_pkg::axl_ftype_t cmdType,
  input wire logic cmdPf,
  output logic connected,
  output logic pendBusy,
  output logic [8:0] seqVars
);
  import axl_pkg::*;
  axl_tx_t phQ, phD;
  axl_frame_t rx, pendQ, pendD, frameQ, frameD;
  logic pendQv, pendDv, connD, keyedQ, keyedD;
  logic [8:0] seqQ, seqD;
  logic validQ, validD, acqQ, acqD, lossQ, lossD, rxOk, rxCmd;

  // Build a frame to the station
  function automatic axl_frame_t mkFrame(axl_ftype_t ft, logic pf, logic cmd);
    axl_frame_t f;
    f.ftype = ft;
    f.pf = pf;
    f.destC = cmd ? CMD_DEST_C : RSP_DEST_C;
    f.srcC = cmd ? CMD_SRC_C : RSP_SRC_C;
    f.dest = peerAddr;
    f.src = ownAddr;
    return f;
  endfunction : mkFrame

  assign rx = lnk.devFrame;
  assign rxOk = lnk.devValid && (rx.dest == ownAddr) && (rx.src == peerAddr);
  assign rxCmd = rx.destC && !rx.srcC;

  ////////////////////////////////////////////////////////////////////////////
  // Procedure and modem next state
  always_comb begin
    phD = phQ;
    pendD = pendQ;
    pendDv = pendQv;
    connD = connected;
    seqD = seqQ;
    frameD = frameQ;
    validD = 1'b0;
    acqD = 1'b0;
    lossD = 1'b0;
    keyedD = keyedQ;
    if (lnk.devTxOn) begin
      keyedD = 1'b1;
    end else if (lnk.devTxOff) begin
      keyedD = 1'b0;
    end
    // Modem: signal, frame, then loss; waits while the station keys
    case (phQ)
      TX_IDLE: begin
        if (pendQv && !keyedQ && !lnk.devTxOn) begin
          acqD = 1'b1;
          phD = TX_WAITQ;
        end
      end
      TX_WAITQ: begin
        frameD = pendQ;
        validD = 1'b1;
        pendDv = 1'b0;
        phD = TX_KEY;
      end
      TX_KEY: begin
        lossD = 1'b1;
        phD = TX_REL;
      end
      TX_REL: begin
        phD = TX_IDLE;
      end
      default: begin
        phD = TX_IDLE;
      end
    endcase
    if (cmdReq && !pendDv) begin
      pendDv = 1'b1;
      pendD = mkFrame(cmdType, (cmdType == FT_SABM || cmdType == FT_DISC) ? 1'b1 : cmdPf, 1'b1);
    end
    // Answers override a queued command
    if (rxOk) begin
      case (rx.ftype)
        FT_SABM: begin
          if (rxCmd) begin
            pendDv = 1'b1;
            pendD = mkFrame(acceptEn ? FT_UA : FT_DM, rx.pf, 1'b0);
            connD = acceptEn;
            seqD = acceptEn ? SEQ_RST : seqQ;
          end
        end
        FT_DISC: begin
          if (rxCmd) begin
            pendDv = 1'b1;
            pendD = mkFrame(connected ? FT_UA : FT_DM, rx.pf, 1'b0);
            connD = 1'b0;
          end
        end
        FT_UA: begin
          if (!rxCmd) begin
            connD = 1'b1;
            seqD = SEQ_RST;
          end
        end
        FT_DM: begin
          if (!rxCmd) begin
            connD = 1'b0;
          end
        end
        default: begin
          if (rxCmd && rx.pf) begin
            pendDv = 1'b1;
            pendD = mkFrame(connected ? FT_RR : FT_DM, 1'b1, 1'b0);
          end
        end
      endcase
    end
  end

  // Registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      phQ <= TX_IDLE;
      pendQ <= '0;
      pendQv <= 1'b0;
      connected <= 1'b0;
      seqQ <= SEQ_RST;
      frameQ <= '0;
      validQ <= 1'b0;
      acqQ <= 1'b0;
      lossQ <= 1'b0;
      keyedQ <= 1'b0;
    end else begin
      phQ <= phD;
      pendQ <= pendD;
      pendQv <= pendDv;
      connected <= connD;
      seqQ <= seqD;
      frameQ <= frameD;
      validQ <= validD;
      acqQ <= acqD;
      lossQ <= lossD;
      keyedQ <= keyedD;
    end
  end

  assign lnk.ptnFrame = frameQ;
  assign lnk.ptnValid = validQ;
  assign lnk.ptnAcq = acqQ;
  assign lnk.ptnLoss = lossQ;
  assign pendBusy = pendQv;
  assign seqVars = seqQ;
endmodule : axl_partner

// ---- dv/axl_link_monitor.sv ----
// Concurrent checks on the carrier that joins station and partner
`timescale 1ns/1ps
module axl_link_monitor
  import axl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire axl_pkg::axl_frame_t devFrame,
  input wire logic devValid,
  input wire logic devTxOn,
  input wire logic devTxOff,
  input wire axl_pkg::axl_frame_t ptnFrame,
  input wire logic ptnValid,
  input wire logic ptnAcq,
  input wire logic ptnLoss
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  // Keying walk of the station and signal burst of the partner
  sequence s_seize;
    devTxOn ##1 devValid ##1 devTxOff;
  endsequence
  sequence s_burst;
    ptnAcq ##1 ptnValid ##1 ptnLoss;
  endsequence
  property p_seize;
    devTxOn |-> s_seize;
  endproperty
  a_seize: assert property (p_seize) else $error("keying walk broken");
  property p_key_first;
    devValid |-> $past(devTxOn);
  endproperty
  a_key_first: assert property (p_key_first) else $error("frame without key on");
  property p_gap;
    devValid |=> !devValid [*3];
  endproperty
  a_gap: assert property (p_gap) else $error("frames too close");
  property p_burst;
    ptnAcq |-> s_burst;
  endproperty
  a_burst: assert property (p_burst) else $error("signal burst broken");
  ////////////////////////////////////////////////////////////////////////////////
  // Command and response bits, poll and final answers
  property p_cmd_bits;
    devValid && devFrame.ftype inside {FT_SABM, FT_DISC} |-> devFrame.destC && !devFrame.srcC && devFrame.pf;
  endproperty
  a_cmd_bits: assert property (p_cmd_bits) else $error("bad command bits");
  property p_rsp_bits;
    devValid && devFrame.ftype inside {FT_UA, FT_DM} |-> !devFrame.destC && devFrame.srcC;
  endproperty
  a_rsp_bits: assert property (p_rsp_bits) else $error("bad response bits");
  property p_ptn_bits;
    ptnValid |-> ptnFrame.destC != ptnFrame.srcC;
  endproperty
  a_ptn_bits: assert property (p_ptn_bits) else $error("partner C bits equal");
  property p_unnum_poll;
    ptnValid && ptnFrame.destC && ptnFrame.pf && ptnFrame.ftype inside {FT_SABM, FT_DISC}
      |-> ##[1:12] devValid && devFrame.pf && devFrame.ftype inside {FT_UA, FT_DM};
  endproperty
  a_unnum_poll: assert property (p_unnum_poll) else $error("no final UA or DM");
  property p_io_poll;
    ptnValid && ptnFrame.destC && ptnFrame.pf && ptnFrame.ftype inside {FT_I, FT_RR, FT_RNR, FT_REJ}
      |-> ##[1:12] devValid && devFrame.pf && devFrame.ftype inside {FT_RR, FT_DM};
  endproperty
  a_io_poll: assert property (p_io_poll) else $error("no final RR or DM");
endmodule : axl_link_monitor

// ---- dv/ax25_link_procedures_tb_top.sv ----
// Self-checking bench for the station facing the distant partner
`timescale 1ns/1ps
module ax25_link_procedures_tb_top;
  import axl_pkg::*;
  localparam logic [ADDR_W-1:0] MY = 8'h3c;
  localparam logic [ADDR_W-1:0] PEER = 8'h5a;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic connReq = 1'b0, ackReq = 1'b0, acceptEn = 1'b1, expValid = 1'b0, cfgWrite = 1'b0;
  logic ptnAccept = 1'b1, cmdReq = 1'b0, cmdPf = 1'b0;
  axl_ftype_t cmdType = FT_I;
  axl_frame_t expFrame = '0;
  axl_frame_t f;
  logic [CNT_W-1:0] t1Cfg = '0;
  logic [7:0] n2Cfg = 8'h0a;
  logic [ADDR_W-1:0] ptnOwn = PEER;
  logic linkUp, connFail, peerOld, expBusy, ptnConn;
  logic [8:0] stSeq, ptnSeq;
  int error_cnt = 0;
  int num_checks = 0;
  always #50 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Both ends joined across the carrier, checker beside it
  axl_link_if axl_link_if_i ();
  axl_station #(.T1_DEFAULT(25'h14)) axl_station_i (.ref_clk(ref_clk), .rst_b(rst_b), .lnk(axl_link_if_i.dev),
    .myAddr(MY), .peerAddr(PEER), .connReq(connReq), .ackReq(ackReq), .acceptEn(acceptEn),
    .expValid(expValid), .expFrame(expFrame), .cfgWrite(cfgWrite), .t1Cfg(t1Cfg), .n2Cfg(n2Cfg),
    .linkUp(linkUp), .connFail(connFail), .peerOld(peerOld), .expBusy(expBusy), .seqVars(stSeq));
  axl_partner axl_partner_i (.ref_clk(ref_clk), .rst_b(rst_b), .lnk(axl_link_if_i.ptn), .ownAddr(ptnOwn),
    .peerAddr(MY), .acceptEn(ptnAccept), .cmdReq(cmdReq), .cmdType(cmdType), .cmdPf(cmdPf),
    .connected(ptnConn), .pendBusy(), .seqVars(ptnSeq));
  axl_link_monitor axl_link_monitor_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .devFrame(axl_link_if_i.devFrame), .devValid(axl_link_if_i.devValid), .devTxOn(axl_link_if_i.devTxOn),
    .devTxOff(axl_link_if_i.devTxOff), .ptnFrame(axl_link_if_i.ptnFrame), .ptnValid(axl_link_if_i.ptnValid),
    .ptnAcq(axl_link_if_i.ptnAcq), .ptnLoss(axl_link_if_i.ptnLoss));
  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : chk
  function automatic axl_frame_t mk(input axl_ftype_t t, input logic p, input logic dc,
    input logic [ADDR_W-1:0] d, input logic [ADDR_W-1:0] s);
    mk = '{ftype: t, pf: p, destC: dc, srcC: ~dc, dest: d, src: s};
  endfunction : mk
  // Waits at falling edges for a frame from the station or the partner
  task automatic wait_frm(input bit dev, output axl_frame_t fr);
    int n;
    logic v;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
      v = dev ? axl_link_if_i.devValid : axl_link_if_i.ptnValid;
    end while (v !== 1'b1 && n < 60);
    fr = dev ? axl_link_if_i.devFrame : axl_link_if_i.ptnFrame;
    chk(v === 1'b1, "expected frame missing");
  endtask : wait_frm
  task automatic ptn_cmd(input axl_ftype_t t, input logic p);
    @(posedge ref_clk);
    cmdType <= t;
    cmdPf <= p;
    cmdReq <= 1'b1;
    @(posedge ref_clk);
    cmdReq <= 1'b0;
  endtask : ptn_cmd
  task automatic st_conn();
    @(posedge ref_clk);
    connReq <= 1'b1;
    @(posedge ref_clk);
    connReq <= 1'b0;
  endtask : st_conn
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_connect();
    int n;
    st_conn();
    wait_frm(1'b1, f);
    chk(f === mk(FT_SABM, 1'b1, 1'b1, PEER, MY), "SABM fields");
    wait_frm(1'b0, f);
    chk(f === mk(FT_UA, 1'b1, 1'b0, MY, PEER), "UA fields");
    @(negedge ref_clk);
    chk(linkUp === 1'b1 && stSeq === 9'h000, "link not up");
    chk(ptnConn === 1'b1 && ptnSeq === 9'h000, "partner not up");
    chk(peerOld === 1'b0, "current peer reported old");
    n = 0;
    repeat (60) begin
      @(negedge ref_clk);
      n += (axl_link_if_i.devValid === 1'b1);
    end
    chk(n == 0, "SABM resent after UA");
  endtask : t_connect
  task automatic t_poll();
    ptn_cmd(FT_I, 1'b1);
    wait_frm(1'b1, f);
    chk(f === mk(FT_RR, 1'b1, 1'b0, PEER, MY), "polled RR");
    @(posedge ref_clk);
    ackReq <= 1'b1;
    @(posedge ref_clk);
    ackReq <= 1'b0;
    wait_frm(1'b1, f);
    chk(f === mk(FT_RR, 1'b0, 1'b0, PEER, MY), "ack RR");
  endtask : t_poll
  task automatic t_exp();
    @(posedge ref_clk);
    expFrame <= mk(FT_REJ, 1'b0, 1'b1, 8'h99, MY);
    expValid <= 1'b1;
    @(posedge ref_clk);
    expValid <= 1'b0;
    @(negedge ref_clk);
    chk(expBusy === 1'b1, "expedited frame not held");
    wait_frm(1'b1, f);
    chk(f === mk(FT_REJ, 1'b0, 1'b1, 8'h99, MY), "expedited frame");
  endtask : t_exp
  task automatic t_disc();
    ptn_cmd(FT_DISC, 1'b1);
    wait_frm(1'b1, f);
    chk(f === mk(FT_UA, 1'b1, 1'b0, PEER, MY), "UA to DISC");
    repeat (3) @(negedge ref_clk);
    chk(linkUp === 1'b0, "link still up");
    ptn_cmd(FT_I, 1'b1);
    wait_frm(1'b1, f);
    chk(f === mk(FT_DM, 1'b1, 1'b0, PEER, MY), "DM when down");
  endtask : t_disc
  task automatic t_refuse();
    @(posedge ref_clk);
    ptnAccept <= 1'b0;
    st_conn();
    wait_frm(1'b0, f);
    chk(f === mk(FT_DM, 1'b1, 1'b0, MY, PEER), "refusal DM");
    @(negedge ref_clk);
    chk(connFail === 1'b1 && linkUp === 1'b0, "refusal not seen");
    @(posedge ref_clk);
    ptnAccept <= 1'b1;
  endtask : t_refuse
  task automatic t_retry();
    int n;
    int k;
    @(posedge ref_clk);
    t1Cfg <= 25'h1e;
    n2Cfg <= 8'h03;
    cfgWrite <= 1'b1;
    ptnOwn <= 8'h77;
    @(posedge ref_clk);
    cfgWrite <= 1'b0;
    st_conn();
    n = 0;
    k = 0;
    while (connFail !== 1'b1 && k < 600) begin
      @(negedge ref_clk);
      k++;
      n += (axl_link_if_i.devValid === 1'b1 && axl_link_if_i.devFrame.ftype === FT_SABM);
    end
    chk(n == 3 && connFail === 1'b1, "SABM attempts");
    chk(linkUp === 1'b0, "link up after give up");
    @(posedge ref_clk);
    ptnOwn <= PEER;
  endtask : t_retry
  task automatic t_ptn_conn();
    ptn_cmd(FT_SABM, 1'b1);
    wait_frm(1'b1, f);
    chk(f === mk(FT_UA, 1'b1, 1'b0, PEER, MY), "UA to SABM");
    repeat (2) @(negedge ref_clk);
    chk(linkUp === 1'b1 && stSeq === 9'h000, "accepted link");
  endtask : t_ptn_conn
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, main sequence and watchdog
  task automatic close_out();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(negedge ref_clk);
    chk(linkUp === 1'b0 && connFail === 1'b0 && expBusy === 1'b0 && stSeq === 9'h000, "reset values");
    t_connect();
    t_poll();
    t_exp();
    t_disc();
    t_refuse();
    t_retry();
    t_ptn_conn();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    close_out();
  end
endmodule : ax25_link_procedures_tb_top
